// [logic/lps_status_regs.sv]
// Purpose: Link protocol status register bank, APB slave
// Assumes: Engine inputs synchronous to pclk
// Notes: Status registers read-only; irq regs write-one-clear/mask
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "lps_defines.svh"
module lps_status_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic na_update,
   input wire logic [2:0] na_value,
   input wire logic acks_busy,
   input wire logic frame_ok,
   input wire logic [7:0] frame_ctrl,
   input wire logic frame_pf,
   input wire logic input_valid,
   input wire logic [4:0] input_code,
   input wire logic reject_valid,
   input wire logic [7:0] reject_byte0,
   input wire logic [7:0] reject_byte1,
   input wire logic [7:0] reject_byte2,
   input wire logic [4:0] state_ord,
   output logic [4:0] protocol_state_number,
   output logic irq
);
   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   logic [2:0] na_r, na_nxt, lna_r, lna_nxt;
   logic ackn_r, ackn_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic pf_r, pf_nxt;
   lps_pkg::lps_code_t code_r, code_nxt;
   logic [7:0] rej0_r, rej0_nxt, rej1_r, rej1_nxt, rej2_r, rej2_nxt;
   lps_pkg::lps_state_t state_r, state_nxt;
   logic [`LPS_IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
   logic [31:0] prdata_r, prdata_nxt;
   logic setup, wr_acc, mapped, code_legal, na_change;

   // --------------------------------------------------------------
   // State number encoding
   // --------------------------------------------------------------
   function automatic lps_pkg::lps_state_t enc_state(input logic [4:0] ord);
      unique case (ord)
         5'd0: enc_state = lps_pkg::LPS_S0;
         5'd1: enc_state = lps_pkg::LPS_S1;
         5'd2: enc_state = lps_pkg::LPS_S2A;
         5'd3: enc_state = lps_pkg::LPS_S2B;
         5'd4: enc_state = lps_pkg::LPS_S3;
         5'd5: enc_state = lps_pkg::LPS_S4;
         5'd6: enc_state = lps_pkg::LPS_S5;
         5'd7: enc_state = lps_pkg::LPS_S6;
         5'd8: enc_state = lps_pkg::LPS_S7;
         5'd9: enc_state = lps_pkg::LPS_S8;
         5'd10: enc_state = lps_pkg::LPS_S9;
         5'd11: enc_state = lps_pkg::LPS_S10;
         5'd12: enc_state = lps_pkg::LPS_S11;
         5'd13: enc_state = lps_pkg::LPS_S12;
         5'd14: enc_state = lps_pkg::LPS_S13;
         5'd15: enc_state = lps_pkg::LPS_S14;
         5'd16: enc_state = lps_pkg::LPS_S15;
         5'd17: enc_state = lps_pkg::LPS_S16;
         5'd18: enc_state = lps_pkg::LPS_S17;
         // Out-of-range ordinal parks at S0
         default: enc_state = lps_pkg::LPS_S0;
      endcase
   endfunction

   // --------------------------------------------------------------
   // Engine-side updates
   // --------------------------------------------------------------
   always_comb begin
      na_change = na_update && (na_value != na_r);
      // Codes 23, 27 and 31 carry no meaning and are dropped
      code_legal = (input_code != 5'h17) && (input_code != 5'h1b) && (input_code != 5'h1f);
      na_nxt = na_r;
      lna_nxt = lna_r;
      if (na_change) begin
         lna_nxt = na_r;
         na_nxt = na_value;
      end
      ackn_nxt = acks_busy;
      ctrl_nxt = frame_ok ? frame_ctrl : ctrl_r;
      pf_nxt = frame_ok ? frame_pf : pf_r;
      code_nxt = code_r;
      if (input_valid && code_legal) begin
         code_nxt = lps_pkg::lps_code_t'(input_code);
      end
      rej0_nxt = reject_valid ? reject_byte0 : rej0_r;
      rej1_nxt = reject_valid ? reject_byte1 : rej1_r;
      rej2_nxt = reject_valid ? reject_byte2 : rej2_r;
      state_nxt = enc_state(state_ord);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         na_r <= 3'h0;
         lna_r <= 3'h0;
         ackn_r <= `LPS_ACKN_RST;
         ctrl_r <= 8'h00;
         pf_r <= 1'b0;
         code_r <= lps_pkg::lps_code_t'(`LPS_CODE_RST);
         rej0_r <= 8'h00;
         rej1_r <= 8'h00;
         rej2_r <= 8'h00;
         state_r <= lps_pkg::LPS_S0;
      end else begin
         na_r <= na_nxt;
         lna_r <= lna_nxt;
         ackn_r <= ackn_nxt;
         ctrl_r <= ctrl_nxt;
         pf_r <= pf_nxt;
         code_r <= code_nxt;
         rej0_r <= rej0_nxt;
         rej1_r <= rej1_nxt;
         rej2_r <= rej2_nxt;
         state_r <= state_nxt;
      end
   end

   // --------------------------------------------------------------
   // APB slave and interrupt registers
   // --------------------------------------------------------------
   always_comb begin
      setup = psel && !penable;
      wr_acc = psel && penable && pwrite;
      unique case (paddr)
         `LPS_OFF_ACK, `LPS_OFF_CTRL, `LPS_OFF_INPUT, `LPS_OFF_REJ0, `LPS_OFF_REJ1,
         `LPS_OFF_REJ2, `LPS_OFF_STATE, `LPS_OFF_IST, `LPS_OFF_IMASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      ev = '0;
      ev[`LPS_EV_NA] = na_change;
      ev[`LPS_EV_FRAME] = frame_ok;
      ev[`LPS_EV_REJ] = reject_valid;
      // Falling busy means every received ack is now processed
      ev[`LPS_EV_ACKDONE] = ackn_r && !acks_busy;
      ev[`LPS_EV_INPUT] = input_valid && code_legal;
      ist_nxt = ist_r;
      imask_nxt = imask_r;
      // Status registers take no writes: only irq regs decode here
      if (wr_acc && paddr == `LPS_OFF_IST) begin
         ist_nxt = ist_r & ~pwdata[`LPS_IRQ_W-1:0];
      end
      if (wr_acc && paddr == `LPS_OFF_IMASK) begin
         imask_nxt = pwdata[`LPS_IRQ_W-1:0];
      end
      // Set wins over a simultaneous clear
      ist_nxt = ist_nxt | ev;
      prdata_nxt = prdata_r;
      if (setup && !pwrite) begin
         prdata_nxt = 32'h0;
         unique case (paddr)
            `LPS_OFF_ACK: prdata_nxt[7:0] = {ackn_r, lna_r, 1'b0, na_r};
            `LPS_OFF_CTRL: prdata_nxt[7:0] = ctrl_r;
            // Test bits 7:6 read as zero
            `LPS_OFF_INPUT: prdata_nxt[7:0] = {2'b00, pf_r, code_r};
            `LPS_OFF_REJ0: prdata_nxt[7:0] = rej0_r;
            `LPS_OFF_REJ1: prdata_nxt[7:0] = rej1_r;
            `LPS_OFF_REJ2: prdata_nxt[7:0] = rej2_r;
            `LPS_OFF_STATE: prdata_nxt[4:0] = state_r;
            `LPS_OFF_IST: prdata_nxt[`LPS_IRQ_W-1:0] = ist_r;
            `LPS_OFF_IMASK: prdata_nxt[`LPS_IRQ_W-1:0] = imask_r;
            default: prdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_r <= '0;
         imask_r <= '0;
         prdata_r <= 32'h0;
      end else begin
         ist_r <= ist_nxt;
         imask_r <= imask_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // Zero-wait slave: read data was latched in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;
   assign protocol_state_number = state_r;
   assign irq = |(ist_r & imask_r);

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_LNA_COPY: assert property (
      na_update && na_value != na_r |=> lna_r == $past(na_r) && na_r == $past(na_value))
      else $error("old ack-expected not saved");
   AST_NA_HOLD: assert property (!na_update |=> $stable(na_r) && $stable(lna_r))
      else $error("ack-expected moved without update");
   AST_ACKN: assert property (acks_busy ##1 !acks_busy
      |=> !ackn_r && ist_r[`LPS_EV_ACKDONE])
      else $error("ack-complete flag wrong");
   AST_CTRL: assert property (frame_ok
      |=> ctrl_r == $past(frame_ctrl) && pf_r == $past(frame_pf))
      else $error("control field not captured");
   AST_PF_HOLD: assert property (!frame_ok |=> $stable(pf_r))
      else $error("poll/final changed without frame");
   AST_CODE: assert property (input_valid && code_legal |=> code_r == $past(input_code))
      else $error("input code not recorded");
   AST_CODE_BAD: assert property (input_valid && input_code == 5'h17
      |=> $stable(code_r))
      else $error("unused code recorded");
   AST_CODE_RST: assert property ($rose(presetn) |-> code_r == 5'h07)
      else $error("input code not 7 after reset");
   AST_REJ: assert property (reject_valid |=> rej0_r == $past(reject_byte0)
      && rej1_r == $past(reject_byte1) && rej2_r == $past(reject_byte2))
      else $error("reject bytes not stored");
   AST_STATE: assert property (state_ord == 5'd10 |=> protocol_state_number == 5'h11)
      else $error("S9 encoding wrong");
   AST_RESV: assert property (setup && !pwrite && paddr == `LPS_OFF_INPUT
      |=> prdata[7:6] == 2'b00 && prdata[5] == $past(pf_r))
      else $error("test bits not zero");
   AST_RO: assert property (wr_acc && paddr == `LPS_OFF_CTRL && !frame_ok
      |=> $stable(ctrl_r))
      else $error("write altered status register");
   AST_IRQ: assert property (ist_r[`LPS_EV_REJ] && imask_r[`LPS_EV_REJ] |-> irq)
      else $error("unmasked status without irq");
   AST_NA_SAME: assert property (na_update && na_value == na_r |=> $stable(lna_r))
      else $error("old ack-expected moved on equal update");
   AST_ACKN_BUSY: assert property (acks_busy |=> ackn_r)
      else $error("ack-complete flag low while busy");
   AST_ACKN_IDLE: assert property (!acks_busy |=> !ackn_r)
      else $error("ack-complete flag high while idle");
   AST_CTRL_HOLD: assert property (!frame_ok |=> $stable(ctrl_r))
      else $error("control field changed without frame");
   AST_CODE_HOLD: assert property (!input_valid |=> $stable(code_r))
      else $error("input code changed without stimulus");
   AST_CODE_UNUSED: assert property (input_valid
      && (input_code == 5'h1b || input_code == 5'h1f) |=> $stable(code_r))
      else $error("reserved code recorded");
   AST_REJ_HOLD: assert property (!reject_valid
      |=> $stable(rej0_r) && $stable(rej1_r) && $stable(rej2_r))
      else $error("reject bytes changed without frame");
   // Spot codes off the plain ordinal sequence; the bench sweeps all
   AST_STATE_S4: assert property (state_ord == 5'd5
      |=> protocol_state_number == 5'h07)
      else $error("S4 encoding wrong");
   AST_STATE_S14: assert property (state_ord == 5'd15
      |=> protocol_state_number == 5'h1a)
      else $error("S14 encoding wrong");
   AST_STATE_S17: assert property (state_ord == 5'd18
      |=> protocol_state_number == 5'h0d)
      else $error("S17 encoding wrong");
   AST_STATE_RANGE: assert property (state_ord > 5'd18
      |=> protocol_state_number == 5'h00)
      else $error("out-of-range ordinal not parked");

   // --------------------------------------------------------------
   // Bus and interrupt assertions
   // --------------------------------------------------------------
   // Read words are checked one edge late: prdata launches at setup
   AST_RD_ACK: assert property (setup && !pwrite && paddr == `LPS_OFF_ACK
      |=> prdata[2:0] == $past(na_r) && prdata[3] == 1'b0
      && prdata[6:4] == $past(lna_r) && prdata[7] == $past(ackn_r))
      else $error("ack word read wrong");
   AST_RD_CTRL: assert property (setup && !pwrite && paddr == `LPS_OFF_CTRL
      |=> prdata == {24'h0, $past(ctrl_r)})
      else $error("control word read wrong");
   AST_RD_INPUT: assert property (setup && !pwrite && paddr == `LPS_OFF_INPUT
      |=> prdata[4:0] == $past(code_r))
      else $error("input code read wrong");
   AST_RD_REJ: assert property (setup && !pwrite && paddr == `LPS_OFF_REJ2
      |=> prdata == {24'h0, $past(rej2_r)})
      else $error("third reject byte read wrong");
   AST_RD_HOLD: assert property (!(setup && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read setup");
   // Engine strobe excluded: it may move the field in the same cycle
   AST_RO_ACK: assert property (wr_acc && paddr == `LPS_OFF_ACK && !na_update
      |=> $stable(na_r) && $stable(lna_r))
      else $error("write altered ack word");
   AST_ERR: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access without error");
   AST_IMASK: assert property (wr_acc && paddr == `LPS_OFF_IMASK && pwdata[`LPS_EV_REJ]
      |=> imask_r[`LPS_EV_REJ])
      else $error("mask write lost");
   AST_IST_SET: assert property (reject_valid |=> ist_r[`LPS_EV_REJ])
      else $error("reject event not latched");
   // Clear only expected when no new event lands in the same cycle
   AST_IST_CLR: assert property (wr_acc && paddr == `LPS_OFF_IST && pwdata[`LPS_EV_REJ]
      && !reject_valid |=> !ist_r[`LPS_EV_REJ])
      else $error("status bit not cleared");

   COV_NA: cover property (na_update && na_value != na_r ##1 ist_r[`LPS_EV_NA]);
   COV_REJ: cover property (reject_valid ##[1:8] setup && paddr == `LPS_OFF_REJ0);
   COV_CLR: cover property (wr_acc && paddr == `LPS_OFF_IST && |ev);
   COV_ACK: cover property (acks_busy ##1 !acks_busy);
   COV_SKIP: cover property (input_valid && input_code == 5'h1b);
endmodule // lps_status_regs

// [logic/lps_defines.svh]
// Purpose: Offsets, field positions, reset values for link status regs
// Assumes: APB, 32-bit data, one aligned word per register
// Notes: Offsets first, then fields and reset values
`ifndef LPS_DEFINES_SVH
`define LPS_DEFINES_SVH
// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define LPS_OFF_ACK 8'h08
`define LPS_OFF_CTRL 8'h0c
`define LPS_OFF_INPUT 8'h10
`define LPS_OFF_REJ0 8'h14
`define LPS_OFF_REJ1 8'h18
`define LPS_OFF_REJ2 8'h1c
`define LPS_OFF_STATE 8'h20
`define LPS_OFF_IST 8'h24
`define LPS_OFF_IMASK 8'h28
// --------------------------------------------------------------
// Fields and reset values
// --------------------------------------------------------------
`define LPS_NA_LSB 0
`define LPS_LNA_LSB 4
`define LPS_ACKN_BIT 7
`define LPS_PF_BIT 5
`define LPS_CODE_RST 5'h07
`define LPS_ACKN_RST 1'b0
`define LPS_IRQ_W 5
`define LPS_EV_NA 0
`define LPS_EV_FRAME 1
`define LPS_EV_REJ 2
`define LPS_EV_ACKDONE 3
`define LPS_EV_INPUT 4
`endif

// [logic/lps_pkg.sv]
// Purpose: Types for link status registers
// Assumes: Codes fixed by the protocol engine
// Notes: None
package lps_pkg;
   typedef enum logic [4:0] {
      LPS_S0 = 5'h00, LPS_S1 = 5'h01, LPS_S2A = 5'h02, LPS_S2B = 5'h03,
      LPS_S3 = 5'h04, LPS_S5 = 5'h05, LPS_S6 = 5'h06, LPS_S4 = 5'h07,
      LPS_S7 = 5'h08, LPS_S8 = 5'h09, LPS_S10 = 5'h0a, LPS_S13 = 5'h0b,
      LPS_S16 = 5'h0c, LPS_S17 = 5'h0d, LPS_S11 = 5'h0f, LPS_S12 = 5'h10,
      LPS_S9 = 5'h11, LPS_S14 = 5'h1a, LPS_S15 = 5'h1b
   } lps_state_t;
   typedef enum logic [4:0] {
      LPS_IN_LSTOP = 5'h00, LPS_IN_LSTART = 5'h01, LPS_IN_T1 = 5'h02,
      LPS_IN_T4 = 5'h03, LPS_IN_UNREC = 5'h04, LPS_IN_IDCMD = 5'h05,
      LPS_IN_BUSY = 5'h06, LPS_IN_IAVAIL = 5'h07, LPS_IN_BCLR = 5'h08,
      LPS_IN_BADNS = 5'h09, LPS_IN_PWINIT = 5'h0a, LPS_IN_PWWAIT = 5'h0b,
      LPS_IN_REJC = 5'h0c, LPS_IN_RRC = 5'h0d, LPS_IN_RNRC = 5'h0e,
      LPS_IN_IFRM = 5'h0f, LPS_IN_UA = 5'h10, LPS_IN_REJFRM = 5'h11,
      LPS_IN_DM = 5'h12, LPS_IN_SABM = 5'h13, LPS_IN_BADNR = 5'h14,
      LPS_IN_IDRSP = 5'h15, LPS_IN_T2 = 5'h16, LPS_IN_IDLE = 5'h18,
      LPS_IN_N2 = 5'h19, LPS_IN_DISC = 5'h1a, LPS_IN_REJR = 5'h1c,
      LPS_IN_RRR = 5'h1d, LPS_IN_RNRR = 5'h1e
   } lps_code_t;
endpackage

// [test/tb_top.sv]
// Purpose: Self-checking bench for the link status register bank
// Assumes: APB with pready tied high; engine strobes are one-cycle pulses
// Notes: Expected values kept in shadow variables updated by the bench
`timescale 1ns/1ps
`include "lps_defines.svh"
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, err;
   logic na_update = 1'b0, acks_busy = 1'b0, frame_ok = 1'b0, frame_pf = 1'b0;
   logic input_valid = 1'b0, reject_valid = 1'b0;
   logic [2:0] na_value = 3'h0, m_na = 3'h0, m_lna = 3'h0;
   logic [7:0] frame_ctrl = 8'h00, rej0 = 8'h00, rej1 = 8'h00, rej2 = 8'h00, m_ctrl = 8'h00;
   logic [4:0] input_code = 5'h00, state_ord = 5'h00, psn, m_code = 5'h07;
   logic m_pf = 1'b0, m_ackn = 1'b0;
   int seed = 42;
   int n_mismatch = 0;
   int checked = 0;
   logic [31:0] v;

   always #2.5 pclk = ~pclk;

   lps_status_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .na_update(na_update), .na_value(na_value), .acks_busy(acks_busy),
      .frame_ok(frame_ok), .frame_ctrl(frame_ctrl), .frame_pf(frame_pf),
      .input_valid(input_valid), .input_code(input_code), .reject_valid(reject_valid),
      .reject_byte0(rej0), .reject_byte1(rej1), .reject_byte2(rej2), .state_ord(state_ord),
      .protocol_state_number(psn), .irq(irq));

   // --------------------------------------------------------------
   // Reporting
   // --------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         n_mismatch++;
      end
   endtask

   // --------------------------------------------------------------
   // Bus and engine drivers
   // --------------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(nm, exp, rd);
   endtask

   // One-cycle strobe; data lines must already be set
   task automatic strobe(input int which);
      @(posedge pclk);
      case (which)
         0: na_update <= 1'b1;
         1: frame_ok <= 1'b1;
         2: input_valid <= 1'b1;
         default: reject_valid <= 1'b1;
      endcase
      @(posedge pclk);
      na_update <= 1'b0;
      frame_ok <= 1'b0;
      input_valid <= 1'b0;
      reject_valid <= 1'b0;
   endtask

   function automatic logic [4:0] exp_state(input logic [4:0] o);
      logic [4:0] tab [0:18] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h05, 5'h06,
         5'h08, 5'h09, 5'h11, 5'h0a, 5'h0f, 5'h10, 5'h0b, 5'h1a, 5'h1b, 5'h0c, 5'h0d};
      return (o > 5'd18) ? 5'h00 : tab[o];
   endfunction

   task automatic check_all();
      rchk("ack", `LPS_OFF_ACK, {24'h0, m_ackn, m_lna, 1'b0, m_na});
      rchk("ctrl", `LPS_OFF_CTRL, {24'h0, m_ctrl});
      rchk("input", `LPS_OFF_INPUT, {26'h0, m_pf, m_code});
      rchk("rej0", `LPS_OFF_REJ0, {24'h0, rej0});
      rchk("rej1", `LPS_OFF_REJ1, {24'h0, rej1});
      rchk("rej2", `LPS_OFF_REJ2, {24'h0, rej2});
      rchk("state", `LPS_OFF_STATE, {27'h0, exp_state(state_ord)});
   endtask

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      check_all();
      check("irq_rst", 32'h0, {31'h0, irq});
      // First pass repeats the held value, which must not shift the old copy
      for (int k = 0; k < 12; k++) begin
         v = (k == 0) ? {29'h0, m_na} : $random(seed);
         na_value <= v[2:0];
         strobe(0);
         if (v[2:0] != m_na) begin
            m_lna = m_na;
            m_na = v[2:0];
         end
         rchk("ack_na", `LPS_OFF_ACK, {24'h0, 1'b0, m_lna, 1'b0, m_na});
      end
      acks_busy <= 1'b1;
      m_ackn = 1'b1;
      check_all();
      acks_busy <= 1'b0;
      m_ackn = 1'b0;
      // Host waits for the ack-complete flag before reallocating buffers
      rd = 32'hffff_ffff;
      for (int t = 0; t < 16 && rd[7] !== 1'b0; t++) begin
         apb(1'b0, `LPS_OFF_ACK, 32'h0);
      end
      check("ack_cmp", 32'h0, {31'h0, rd[7]});
      check_all();
      repeat (4) begin
         v = $random(seed);
         frame_ctrl <= v[7:0];
         frame_pf <= v[8];
         strobe(1);
         m_ctrl = v[7:0];
         m_pf = v[8];
         check_all();
      end
      for (int c = 0; c < 32; c++) begin
         input_code <= 5'(c);
         strobe(2);
         if (!(c inside {23, 27, 31})) m_code = 5'(c);
         rchk("code", `LPS_OFF_INPUT, {26'h0, m_pf, m_code});
      end
      repeat (3) begin
         v = $random(seed);
         rej0 <= v[7:0];
         rej1 <= v[15:8];
         rej2 <= v[23:16];
         strobe(3);
         check_all();
      end
      for (int o = 0; o < 21; o++) begin
         @(posedge pclk);
         state_ord <= 5'(o);
         repeat (2) @(posedge pclk);
         #1 check("state_num", {27'h0, exp_state(5'(o))}, {27'h0, psn});
      end
      // Writes to status words carry random data and must change nothing
      for (int a = 8; a <= 32; a += 4) begin
         apb(1'b1, 8'(a), $random(seed));
      end
      check_all();
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped_err", 32'h1, {31'h0, err});
      check("unmapped_data", 32'h0, rd);
      // Every event kind has fired by now
      rchk("ist_all", `LPS_OFF_IST, 32'h1f);
      // Interrupt: clear all, unmask reject event only
      apb(1'b1, `LPS_OFF_IST, 32'h1f);
      apb(1'b1, `LPS_OFF_IMASK, 32'h04);
      rchk("imask", `LPS_OFF_IMASK, 32'h04);
      rchk("ist_clr", `LPS_OFF_IST, 32'h0);
      check("irq_idle", 32'h0, {31'h0, irq});
      strobe(3);
      @(posedge pclk);
      #1 check("irq_set", 32'h1, {31'h0, irq});
      apb(1'b0, `LPS_OFF_IST, 32'h0);
      check("ist_rej", 32'h4, rd & 32'h4);
      apb(1'b1, `LPS_OFF_IMASK, 32'h0);
      #1 check("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, `LPS_OFF_IMASK, 32'h04);
      #1 check("irq_unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, `LPS_OFF_IST, 32'h04);
      #1 check("irq_cleared", 32'h0, {31'h0, irq});
      // Reject frame lands in the very cycle of its own clear: set must win
      fork
         apb(1'b1, `LPS_OFF_IST, 32'h04);
         begin
            repeat (2) @(posedge pclk);
            reject_valid <= 1'b1;
            @(posedge pclk);
            reject_valid <= 1'b0;
         end
      join
      #1 check("irq_set_wins", 32'h1, {31'h0, irq});
      apb(1'b0, `LPS_OFF_IST, 32'h0);
      check("ist_set_wins", 32'h4, rd & 32'h4);
      tally_and_finish();
   end

   // Guard against a hang anywhere in the sequence
   initial begin
      repeat (50000) @(posedge pclk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule // tb_top
